// *** rtl/phy_host_consts.svh ***
// constants of the transceiver host control register bank
// assumes inclusion by the package and the bank module only
`ifndef PHY_HOST_CONSTS_SVH
`define PHY_HOST_CONSTS_SVH

// ==========================================
// register offsets
`define OFS_CONTROL_ZERO 6'h00
`define OFS_CONTROL_ONE 6'h01
`define OFS_STATUS_FLAGS 6'h02
`define OFS_RESERVED 6'h03
`define OFS_EVENT_STATUS 6'h04
`define OFS_EVENT_MASK 6'h05
`define WINDOW_BYTES 48

// ==========================================
// control zero fields
`define BIT_PHY_ENABLE 7
`define BIT_AUTONEG_DIS 6
`define BIT_HALT_IN_WAIT 5
`define BIT_FAST_PLL_OFF 4
`define BIT_SLOW_PLL_OFF 3
`define BIT_LED_DRIVE 2
`define BIT_IRQ_ENABLE 0
// status fields
`define BIT_FAST_DIS_STAT 5
`define BIT_SLOW_DIS_STAT 4
`define BIT_IRQ_FLAG 0
// event status fields
`define EV_LINK_UP 0
`define EV_LINK_DOWN 1
`define EV_ENABLED 2
`define EV_COUNT 3

// ==========================================
// reset values
`define RST_CONTROL_ZERO 8'h00
`define RST_CONTROL_ONE 8'h00
`define RST_EVENT 8'h00

// ==========================================
// timing: start-up delay before negotiation
`define STARTUP_US 100
`define CLK_MHZ 20
`define STARTUP_CYCLES (`STARTUP_US * `CLK_MHZ)
// collision and activity flash hold, in ms
`define FLASH_MS 50
`define FLASH_CYCLES (`FLASH_MS * 1000 * `CLK_MHZ)

`endif

// *** rtl/phy_host_pkg.sv ***
// types shared by the transceiver host control bank
// assumes the constants header is available on the include path
package phy_host_pkg;
   `include "phy_host_consts.svh"

   // settings handed to the transceiver core
   typedef struct packed {
      logic run;
      logic autonegEnableBit;
      logic autonegStart;
      logic manualMode;
      logic fastPllOff;
      logic slowPllOff;
      logic [4:0] mgmtAddress;
      logic mgmtLoad;
   } core_ctrl_t;

   // link state reported by the transceiver core
   typedef struct packed {
      logic linkUp;
      logic fullDuplex;
      logic fastSpeed;
      logic collision;
      logic rxData;
      logic fastPllDown;
      logic slowPllDown;
      logic irqCondition;
   } core_stat_t;

   typedef struct packed {
      logic collision;
      logic duplex;
      logic speed;
      logic link;
      logic activity;
   } led_t;

   typedef enum logic [1:0] {
      PHY_OFF,
      PHY_STARTUP,
      PHY_RUNNING
   } phy_state_t;
endpackage

// *** rtl/phy_host_control_regs.sv ***
// register bank steering the on-chip transceiver core
// assumes synchronous inputs, one clock, a plain strobe bus from the processor
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "phy_host_consts.svh"
module phy_host_control_regs #(
   parameter int STARTUP_CYCLES = `STARTUP_CYCLES,
   parameter int FLASH_CYCLES = `FLASH_CYCLES
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clkEnable,
   input wire logic [5:0] busAddr,
   input wire logic [7:0] busWdata,
   input wire logic busWrite,
   input wire logic busRead,
   output logic [7:0] busRdata,
   input wire logic waitMode,
   input wire phy_host_pkg::core_stat_t coreStat,
   output phy_host_pkg::core_ctrl_t coreCtrl,
   output phy_host_pkg::led_t ledOut,
   output logic irqRequest,
   output logic eventIrq,
   output logic pairOutOe,
   output logic pairInOe
);
   import phy_host_pkg::*;

   // ==========================================
   // helpers
   function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
      hit = (a == ofs);
   endfunction

   // stretch and start-up counter widths, sized to hold their reload values
   localparam int FW = $clog2(FLASH_CYCLES + 1);
   localparam int SW = $clog2(STARTUP_CYCLES + 1);

   logic [7:0] controlZero;
   logic [4:0] mgmtAddrReg;
   logic irqFlag;
   logic [`EV_COUNT-1:0] eventStatus;
   logic [`EV_COUNT-1:0] eventMask;
   logic enablePrev;
   logic linkPrev;
   phy_state_t phyState;
   logic [SW-1:0] startupCount;
   logic [FW-1:0] colCount;
   logic [FW-1:0] actCount;
   logic latchedAnDis;

   logic wrZero, wrOne, wrStat, wrEvent, wrMask;
   logic enable;
   logic enableRise;
   logic halted;
   logic [`EV_COUNT-1:0] eventSet;

   assign wrZero = busWrite && hit(busAddr, `OFS_CONTROL_ZERO);
   assign wrOne = busWrite && hit(busAddr, `OFS_CONTROL_ONE);
   assign wrStat = busWrite && hit(busAddr, `OFS_STATUS_FLAGS);
   assign wrEvent = busWrite && hit(busAddr, `OFS_EVENT_STATUS);
   assign wrMask = busWrite && hit(busAddr, `OFS_EVENT_MASK);
   assign enable = controlZero[`BIT_PHY_ENABLE];
   assign enableRise = enable && !enablePrev;
   // wait-mode halt acts as a disable while the processor sleeps
   assign halted = controlZero[`BIT_HALT_IN_WAIT] && waitMode;

   // ==========================================
   // software registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         controlZero <= `RST_CONTROL_ZERO;
         mgmtAddrReg <= 5'h00;
      end else if (clkEnable) begin
         if (wrZero) begin
            controlZero <= busWdata;
         end
         if (wrOne) begin
            mgmtAddrReg <= busWdata[4:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         enablePrev <= 1'b0;
         latchedAnDis <= 1'b0;
      end else if (clkEnable) begin
         enablePrev <= enable;
         if (enableRise) begin
            latchedAnDis <= controlZero[`BIT_AUTONEG_DIS];
         end
      end
   end

   // ==========================================
   // interrupt flag: set wins over the clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irqFlag <= 1'b0;
      end else if (clkEnable) begin
         if (coreStat.irqCondition && enable && !halted) begin
            irqFlag <= 1'b1;
         end else if (wrStat && busWdata[`BIT_IRQ_FLAG]) begin
            irqFlag <= 1'b0;
         end
      end
   end

   // the request is held low in wait halt so the core cannot wake the cpu
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irqRequest <= 1'b0;
      end else if (clkEnable) begin
         irqRequest <= irqFlag && controlZero[`BIT_IRQ_ENABLE] && !halted;
      end
   end

   // ==========================================
   // bank events: link up, link down, core brought up
   always_comb begin
      eventSet = '0;
      eventSet[`EV_LINK_UP] = coreStat.linkUp && !linkPrev;
      eventSet[`EV_LINK_DOWN] = !coreStat.linkUp && linkPrev;
      eventSet[`EV_ENABLED] = enableRise;
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         linkPrev <= 1'b0;
         eventStatus <= '0;
         eventMask <= '0;
      end else if (clkEnable) begin
         linkPrev <= coreStat.linkUp;
         eventStatus <= eventSet | (eventStatus & ~(wrEvent ? busWdata[`EV_COUNT-1:0] : '0));
         if (wrMask) begin
            eventMask <= busWdata[`EV_COUNT-1:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         eventIrq <= 1'b0;
      end else if (clkEnable) begin
         eventIrq <= |(eventStatus & eventMask);
      end
   end

   // ==========================================
   // start-up sequence
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phyState <= PHY_OFF;
         startupCount <= '0;
      end else if (clkEnable) begin
         case (phyState)
            PHY_OFF: begin
               if (enableRise) begin
                  phyState <= PHY_STARTUP;
                  startupCount <= SW'(STARTUP_CYCLES);
               end
            end
            PHY_STARTUP: begin
               if (!enable) begin
                  phyState <= PHY_OFF;
               end else if (startupCount <= SW'(1)) begin
                  phyState <= PHY_RUNNING;
               end else begin
                  startupCount <= startupCount - SW'(1);
               end
            end
            PHY_RUNNING: begin
               if (!enable) begin
                  phyState <= PHY_OFF;
               end
            end
            default: begin
               phyState <= PHY_OFF;
            end
         endcase
      end
   end

   // ==========================================
   // core controls
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         coreCtrl <= '0;
      end else if (clkEnable) begin
         coreCtrl.run <= enable && !halted;
         coreCtrl.mgmtLoad <= enableRise;
         if (enableRise) begin
            coreCtrl.autonegEnableBit <= !controlZero[`BIT_AUTONEG_DIS];
            coreCtrl.mgmtAddress <= mgmtAddrReg;
         end
         // one-cycle start pulse once the start-up delay has run out
         coreCtrl.autonegStart <= (phyState == PHY_STARTUP) && enable
            && (startupCount <= SW'(1)) && !latchedAnDis;
         coreCtrl.manualMode <= (phyState == PHY_RUNNING) && latchedAnDis;
         coreCtrl.fastPllOff <= controlZero[`BIT_FAST_PLL_OFF];
         coreCtrl.slowPllOff <= controlZero[`BIT_SLOW_PLL_OFF];
      end
   end

   // line pins float until the core actually runs
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pairOutOe <= 1'b0;
         pairInOe <= 1'b0;
      end else if (clkEnable) begin
         pairOutOe <= (phyState == PHY_RUNNING) && !halted;
         pairInOe <= (phyState == PHY_RUNNING) && !halted;
      end
   end

   // ==========================================
   // LED drive; short events are stretched so they are visible
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         colCount <= '0;
         actCount <= '0;
      end else if (clkEnable) begin
         if (coreStat.collision && !coreStat.fullDuplex) begin
            colCount <= FW'(FLASH_CYCLES);
         end else if (colCount != '0) begin
            colCount <= colCount - FW'(1);
         end
         if (coreStat.rxData) begin
            actCount <= FW'(FLASH_CYCLES);
         end else if (actCount != '0) begin
            actCount <= actCount - FW'(1);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ledOut <= '0;
      end else if (clkEnable) begin
         if (controlZero[`BIT_LED_DRIVE] && coreCtrl.run) begin
            ledOut.collision <= colCount != '0;
            ledOut.duplex <= coreStat.fullDuplex;
            ledOut.speed <= coreStat.fastSpeed;
            ledOut.link <= coreStat.linkUp;
            ledOut.activity <= actCount != '0;
         end else begin
            ledOut <= '0;
         end
      end
   end

   // ==========================================
   // read port, data in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busRdata <= 8'h00;
      end else if (clkEnable) begin
         busRdata <= 8'h00;
         if (busRead) begin
            // whole 48-byte window decodes; unused slots read zero
            case (busAddr)
               `OFS_CONTROL_ZERO: busRdata <= controlZero;
               `OFS_CONTROL_ONE: busRdata <= {3'b000, mgmtAddrReg};
               `OFS_STATUS_FLAGS: begin
                  busRdata[`BIT_FAST_DIS_STAT] <= coreStat.fastPllDown;
                  busRdata[`BIT_SLOW_DIS_STAT] <= coreStat.slowPllDown;
                  busRdata[`BIT_IRQ_FLAG] <= irqFlag;
               end
               `OFS_EVENT_STATUS: busRdata <= {5'b00000, eventStatus};
               `OFS_EVENT_MASK: busRdata <= {5'b00000, eventMask};
               default: busRdata <= 8'h00;
            endcase
         end
      end
   end
endmodule // phy_host_control_regs

// *** sim/phy_core_model.sv ***
// stand-in for the transceiver core: link comes up LINK_DELAY cycles after run
// assumes the bench supplies the wanted line state on want
`timescale 1ns/1ps
module phy_core_model #(
   parameter int LINK_DELAY = 6
) (
   input wire logic core_clk,
   input wire phy_host_pkg::core_ctrl_t coreCtrl,
   input wire phy_host_pkg::core_stat_t want,
   output phy_host_pkg::core_stat_t coreStat
);
   import phy_host_pkg::*;
   int cnt;
   logic up;
   always_ff @(posedge core_clk) begin
      cnt <= !coreCtrl.run ? 0 : (cnt < LINK_DELAY ? cnt + 1 : cnt);
   end
   assign up = coreCtrl.run && cnt == LINK_DELAY;
   // collisions only exist in half duplex; an off core reports both plls down
   assign coreStat = '{up, up & want.fullDuplex, up & want.fastSpeed, up & want.collision & !want.fullDuplex,
      up & want.rxData, coreCtrl.fastPllOff | !coreCtrl.run, coreCtrl.slowPllOff | !coreCtrl.run,
      coreCtrl.run & want.irqCondition};
endmodule // phy_core_model

// *** sim/phy_host_control_regs_monitor.sv ***
// port-level checker for the transceiver host control bank
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module phy_host_control_regs_monitor #(
   parameter int STARTUP_CYCLES = 4,
   parameter int FLASH_CYCLES = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [5:0] busAddr,
   input wire logic [7:0] busWdata,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [7:0] busRdata,
   input wire phy_host_pkg::core_ctrl_t coreCtrl,
   input wire phy_host_pkg::led_t ledOut,
   input wire logic irqRequest,
   input wire logic eventIrq,
   input wire logic pairOutOe
);
   import phy_host_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // assertions
   chk_read_idle: assert property (!$past(busRead) |-> busRdata == 8'h00)
      else $error("read data not zero outside read cycle");
   chk_unmapped_read: assert property (busRead && (busAddr == 6'h03 || busAddr > 6'h05) |=> busRdata == 8'h00)
      else $error("reserved offset read not zero");
   chk_led_gate: assert property (busWrite && busAddr == 6'h00 && !busWdata[2] |=> ##1 ledOut == 5'h00)
      else $error("led driven while disabled");
   chk_fast_pll: assert property (busWrite && busAddr == 6'h00 |=> ##1 coreCtrl.fastPllOff == $past(busWdata[4], 2))
      else $error("fast pll off not following control");
   chk_irq_gate: assert property (busWrite && busAddr == 6'h00 && !busWdata[0] |=> ##1 !irqRequest)
      else $error("irq forwarded while disabled");
   chk_load_pulse: assert property (coreCtrl.mgmtLoad |-> coreCtrl.run ##1 !coreCtrl.mgmtLoad)
      else $error("load pulse malformed");
   chk_copy_hold: assert property (!coreCtrl.mgmtLoad |-> $stable(coreCtrl.mgmtAddress)
      && $stable(coreCtrl.autonegEnableBit))
      else $error("copied settings moved without enable rise");
   chk_start_quiet: assert property (coreCtrl.mgmtLoad |-> !pairOutOe [*4])
      else $error("pair pins active during start-up");
   cover property (coreCtrl.autonegStart);
   cover property (irqRequest);
   cover property (eventIrq);
endmodule // phy_host_control_regs_monitor

bind phy_host_control_regs phy_host_control_regs_monitor #(.STARTUP_CYCLES(STARTUP_CYCLES),
   .FLASH_CYCLES(FLASH_CYCLES)) phy_host_control_regs_monitor_inst (.core_clk, .sys_rst, .busAddr,
   .busWdata, .busWrite, .busRead, .busRdata, .coreCtrl, .ledOut, .irqRequest, .eventIrq, .pairOutOe);

// *** sim/phy_host_control_regs_bench.sv ***
// self-checking bench for the transceiver host control bank
// assumes the checker is bound in and the core model sits on the far side
`timescale 1ns/1ps
module phy_host_control_regs_bench;
   import phy_host_pkg::*;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [5:0] busAddr = 6'h00;
   logic [7:0] busWdata = 8'h00;
   logic busWrite = 1'b0;
   logic busRead = 1'b0;
   logic waitMode = 1'b0;
   logic clkEnable = 1'b1;
   logic [7:0] busRdata;
   logic irqRequest, eventIrq, pairOutOe, pairInOe, rdPending = 1'b0;
   core_stat_t coreStat;
   core_stat_t want = 8'h60;
   core_ctrl_t coreCtrl;
   led_t ledOut;
   logic [7:0] expQ[$];
   integer seed = 32'hD3C593A9;
   int failures = 0;
   int testsRun = 0;
   int cycles = 0;
   phy_host_control_regs #(.STARTUP_CYCLES(4), .FLASH_CYCLES(8)) phy_host_control_regs_inst (.core_clk,
      .sys_rst, .clkEnable, .busAddr, .busWdata, .busWrite, .busRead, .busRdata, .waitMode,
      .coreStat, .coreCtrl, .ledOut, .irqRequest, .eventIrq, .pairOutOe, .pairInOe);
   phy_core_model phy_core_model_inst (.core_clk, .coreCtrl, .want, .coreStat);
   initial forever #25 core_clk = ~core_clk;
   // ==========================================
   // tasks
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      testsRun++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("failures=%0d testsRun=%0d", failures, testsRun);
      if (failures == 0 && testsRun > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge core_clk);
      busWrite <= 1'b1;
      busRead <= 1'b0;
      busAddr <= a;
      busWdata <= d;
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      @(posedge core_clk);
      busRead <= 1'b1;
      busWrite <= 1'b0;
      busAddr <= a;
      expQ.push_back(e);
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge core_clk);
         busWrite <= 1'b0;
         busRead <= 1'b0;
      end
      #1;
   endtask
   task automatic pulse(input core_stat_t p);
      @(posedge core_clk);
      want <= want | p;
      @(posedge core_clk);
      want <= want & ~p;
   endtask
   task automatic waitLink();
      for (int i = 0; i < 40 && ledOut.link !== 1'b1; i++) tick(1);
   endtask
   // read data watcher and hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (rdPending) cmp(busRdata, expQ.pop_front());
      rdPending <= busRead;
      if (cycles == 2000) begin
         failures++;
         summarize();
      end
   end
   // ==========================================
   // scenarios
   initial begin
      logic [7:0] v;
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(6'h00, 8'h00);
      rd(6'h01, 8'h00);
      rd(6'h02, 8'h30);
      tick(2);
      cmp({6'h00, pairOutOe, pairInOe}, 8'h00);
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed)) & 8'h7D;
         wr(6'h00, v);
         rd(6'h00, v);
         tick(2);
         cmp({6'h00, coreCtrl.fastPllOff, coreCtrl.slowPllOff}, {6'h00, v[4:3]});
      end
      for (int d = 0; d < 2; d++) begin
         v = 8'($random(seed)) & 8'h1F;
         wr(6'h01, v);
         wr(6'h00, 8'h00);
         wr(6'h00, {1'b1, d[0], 6'h05});
         tick(2);
         cmp({3'h0, coreCtrl.mgmtAddress}, v);
         cmp({7'h00, coreCtrl.autonegEnableBit}, {7'h00, !d[0]});
         wr(6'h01, ~v & 8'h1F);
         wr(6'h00, {1'b1, !d[0], 6'h05});
         tick(2);
         cmp({2'h0, coreCtrl.mgmtAddress, coreCtrl.autonegEnableBit}, {v[6:0], !d[0]});
      end
      waitLink();
      cmp({5'h00, ledOut.duplex, ledOut.speed, ledOut.link}, 8'h07);
      cmp({5'h00, coreCtrl.manualMode, pairOutOe, pairInOe}, 8'h07);
      wr(6'h04, 8'h07);
      wr(6'h05, 8'h02);
      wr(6'h00, 8'h05);
      tick(5);
      cmp({7'h00, eventIrq}, 8'h01);
      rd(6'h04, 8'h02);
      wr(6'h04, 8'h02);
      tick(3);
      cmp({7'h00, eventIrq}, 8'h00);
      wr(6'h00, 8'h85);
      @(posedge core_clk);
      busWrite <= 1'b0;
      want.fullDuplex <= 1'b0;
      waitLink();
      cmp({6'h00, coreCtrl.manualMode, pairOutOe}, 8'h01);
      pulse(8'h18);
      tick(2);
      cmp({5'h00, ledOut.collision, ledOut.activity, ledOut.duplex}, 8'h06);
      wr(6'h00, 8'h81);
      tick(2);
      cmp({3'h0, ledOut}, 8'h00);
      pulse(8'h01);
      tick(3);
      cmp({7'h00, irqRequest}, 8'h01);
      rd(6'h02, 8'h01);
      @(posedge core_clk);
      busRead <= 1'b0;
      waitMode <= 1'b1;
      wr(6'h00, 8'hA1);
      tick(3);
      cmp({6'h00, irqRequest, coreCtrl.run}, 8'h00);
      wr(6'h00, 8'h80);
      waitMode <= 1'b0;
      tick(2);
      cmp({7'h00, irqRequest}, 8'h00);
      wr(6'h00, 8'h81);
      tick(3);
      cmp({7'h00, irqRequest}, 8'h01);
      wr(6'h02, 8'h01);
      tick(3);
      cmp({7'h00, irqRequest}, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr(i == 0 ? 6'h03 : (i == 1 ? 6'h06 : 6'h2F), 8'hFF);
         rd(i == 0 ? 6'h03 : (i == 1 ? 6'h06 : 6'h2F), 8'h00);
      end
      // a frozen bank must ignore a disabling write
      @(posedge core_clk);
      busRead <= 1'b0;
      clkEnable <= 1'b0;
      wr(6'h00, 8'h00);
      tick(3);
      cmp({7'h00, coreCtrl.run}, 8'h01);
      @(posedge core_clk);
      clkEnable <= 1'b1;
      rd(6'h00, 8'h81);
      tick(3);
      summarize();
   end
endmodule // phy_host_control_regs_bench
